// file: rtl/adc_readout_defs.svh
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

// ----------------------------------------
// Sizes and counts
// ----------------------------------------
`define CHANNEL_COUNT     4'h8
`define CONV_BITS         14
`define SERIAL_LAST_EDGE  5'h0E
`define SERIAL_CH_BITS    5'h10
`define SERIAL_CH_PER_LINE 4'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESULT_RESET      14'h0000

`endif

// file: rtl/adc_readout_mode_and_first_flag.sv
`timescale 1ns/1ps
`include "adc_readout_defs.svh"

// Contract
// - Select high: sample top pin for mode
// - Word mode: top pin outputs MSB during read
// - Word mode: marker rises presenting channel 1
// - Word mode: marker falls on next strobe
// - Byte mode: marker rises on channel 1 byte
// - Byte mode: stays high second, falls third
// - Serial: marker rises on chip-select fall
// - Serial: marker falls on 14th clock fall
// - Marker tri-stated until first chip-select fall
// - Byte order input picks high or low first
module adc_readout_mode_and_first_flag (
  input  wire logic                         mclk_i,                // System clock
  input  wire logic                         rst_i,                 // Sync reset, high
  input  wire logic                         ce_i,                  // Clock enable
  input  wire logic                         conv_done_i,           // New results latched, pulse
  input  wire logic [8*`CONV_BITS-1:0]      results_i,             // Eight results, ch1 low
  input  wire logic                         interface_select_i,    // Mode strap
  input  wire logic                         top_bit_or_byte_sel_i, // Top pin input side
  input  wire logic                         byte_order_select_i,   // High byte first when high
  input  wire logic                         cs_n_i,                // Chip select, low
  input  wire logic                         rd_n_i,                // Read strobe, low
  input  wire logic                         sclk_i,                // Serial clock
  output adc_readout_pkg::mode_t            mode_o,                // Decoded mode
  output logic [15:0]                       data_bus_o,            // Parallel data
  output logic                              top_bit_oe_o,          // Top pin drive enable
  output logic                              data_bus_oe_o,         // Low pins drive enable
  output logic                              serial_out_a_o,        // Channels 1-4 serial
  output logic                              serial_out_b_o,        // Channels 5-8 serial
  output logic                              first_channel_marker_o, // Channel 1 marker
  output logic                              first_channel_marker_oe_o // Marker drive enable
);
  import adc_readout_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mode_t                    mode;
    logic [8*`CONV_BITS-1:0]  res;
    logic [2:0]               chan;
    logic                     byte2;
    logic [4:0]               bitcnt;
    logic [1:0]               sch;
    logic                     cs_d;
    logic                     rd_d;
    logic                     sclk_d;
    logic [15:0]              dbus;
    logic                     top_oe;
    logic                     db_oe;
    logic                     sa;
    logic                     sb;
    logic                     mark;
    logic                     mark_oe;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Per-channel result views
  logic [`CONV_BITS-1:0] ch_res [8];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      assign ch_res[g] = s_reg.res[g*`CONV_BITS +: `CONV_BITS];
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic        cs_fall;
    logic        rd_fall;
    logic        sclk_fall;
    logic [15:0] word;
    logic [4:0]  bidx;
    cs_fall   = 1'b0;
    rd_fall   = 1'b0;
    sclk_fall = 1'b0;
    word      = 16'h0000;
    bidx      = 5'h00;
    s_next    = s_reg;
    // Keep the last pin samples for edge detection
    s_next.cs_d   = cs_n_i;
    s_next.rd_d   = rd_n_i;
    s_next.sclk_d = sclk_i;
    // Strobe and clock falls count only while selected
    cs_fall   = s_reg.cs_d & ~cs_n_i;
    rd_fall   = s_reg.rd_d & ~rd_n_i & ~cs_n_i;
    sclk_fall = s_reg.sclk_d & ~sclk_i & ~cs_n_i;

    // Mode from the straps, sampled while idle
    if (cs_n_i) begin
      if (!interface_select_i) begin
        s_next.mode = MODE_WORD;
      end else if (top_bit_or_byte_sel_i) begin
        s_next.mode = MODE_BYTE;
      end else begin
        s_next.mode = MODE_SERIAL;
      end
    end

    // New conversion restarts the readout at channel 1
    if (conv_done_i) begin
      s_next.res    = results_i;
      s_next.chan   = 3'h0;
      s_next.byte2  = 1'b0;
      s_next.bitcnt = 5'h00;
      s_next.sch    = 2'h0;
    end

    // Marker driven from first chip-select fall on
    if (cs_fall) begin
      s_next.mark_oe = 1'b1;
    end

    // Per-mode readout
    case (s_reg.mode)
      MODE_WORD: begin
        // Top pin and bus follow the read strobe
        s_next.top_oe = ~cs_n_i & ~rd_n_i;
        s_next.db_oe  = ~cs_n_i & ~rd_n_i;
        // Each strobe fall presents the next channel
        if (rd_fall && !conv_done_i) begin
          word = {ch_res[s_reg.chan], 2'b00};
          s_next.dbus = word;
          s_next.mark = (s_reg.chan == 3'h0);
          s_next.chan = s_reg.chan + 3'h1;
        end
      end
      MODE_BYTE: begin
        // Top pin stays an input here
        s_next.top_oe = 1'b0;
        s_next.db_oe  = ~cs_n_i & ~rd_n_i;
        if (rd_fall && !conv_done_i) begin
          word = {2'b00, ch_res[s_reg.chan]};
          // High byte first when order input high
          if (byte_order_select_i ^ s_reg.byte2) begin
            s_next.dbus = {8'h00, word[15:8]};
          end else begin
            s_next.dbus = {8'h00, word[7:0]};
          end
          s_next.mark  = (s_reg.chan == 3'h0);
          s_next.byte2 = ~s_reg.byte2;
          // Channel advances after its second byte
          if (s_reg.byte2) begin
            s_next.chan = s_reg.chan + 3'h1;
          end
        end
      end
      MODE_SERIAL: begin
        // Parallel pins stay released
        s_next.top_oe = 1'b0;
        s_next.db_oe  = 1'b0;
        if (cs_fall && s_reg.sch == 2'h0 && s_reg.bitcnt == 5'h00) begin
          s_next.mark = 1'b1;
        end
        if (sclk_fall && !conv_done_i) begin
          // Fourteenth clock fall of channel 1
          if (s_reg.sch == 2'h0 && s_reg.bitcnt == `SERIAL_LAST_EDGE - 5'h01) begin
            s_next.mark = 1'b0;
          end
          // Sixteen clocks per channel, then the next one
          if (s_reg.bitcnt == `SERIAL_CH_BITS - 5'h01) begin
            s_next.bitcnt = 5'h00;
            s_next.sch    = s_reg.sch + 2'h1;
          end else begin
            s_next.bitcnt = s_reg.bitcnt + 5'h01;
          end
        end
        // MSB first; bits past the result read as zero
        bidx = 5'(`CONV_BITS - 1) - s_next.bitcnt;
        if (s_next.bitcnt < 5'(`CONV_BITS)) begin
          s_next.sa = ch_res[{1'b0, s_next.sch}][bidx[3:0]];
          s_next.sb = ch_res[{1'b1, s_next.sch}][bidx[3:0]];
        end else begin
          s_next.sa = 1'b0;
          s_next.sb = 1'b0;
        end
      end
      default: begin
        // Unused code falls back to word mode
        s_next.mode = MODE_WORD;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // State register, frozen while clock enable is low
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.res  <= {8{`RESULT_RESET}};
      s_reg.cs_d <= 1'b1;
      s_reg.rd_d <= 1'b1;
      s_reg.sclk_d <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Straight from the state register
  assign mode_o                    = s_reg.mode;
  assign data_bus_o                = s_reg.dbus;
  assign top_bit_oe_o              = s_reg.top_oe;
  assign data_bus_oe_o             = s_reg.db_oe;
  assign serial_out_a_o            = s_reg.sa;
  assign serial_out_b_o            = s_reg.sb;
  assign first_channel_marker_o    = s_reg.mark;
  assign first_channel_marker_oe_o = s_reg.mark_oe;

endmodule

// file: rtl/adc_readout_pkg.sv
package adc_readout_pkg;
  // Interface mode taken from the straps
  typedef enum logic [1:0] {
    MODE_WORD,
    MODE_BYTE,
    MODE_SERIAL
  } mode_t;
endpackage

// file: verification/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
  input  wire logic       mclk_i,  // Clock
  output logic            cs_n_o,  // Chip select
  output logic            rd_n_o,  // Read strobe
  output logic            sclk_o,  // Serial clock, idles high
  output logic [2:0]      strap_o  // Select, top pin, byte order
);
  // Idle levels from time zero
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    sclk_o = 1'b1;
    strap_o = 3'h0;
  end
  // Move just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Straps change only while deselected, then held
  task automatic set_strap(input logic [2:0] s);
    step(1);
    strap_o = s;
    step(3);
  endtask
  // Select edge with settling time
  task automatic frame(input logic v);
    step(1);
    cs_n_o = v;
    step(3);
  endtask
  // Read strobe, four cycles low, in two halves
  task automatic rd_begin();
    step(1);
    rd_n_o = 1'b0;
    step(2);
  endtask
  task automatic rd_end();
    step(2);
    rd_n_o = 1'b1;
    step(3);
  endtask
  task automatic rd_pulse();
    rd_begin();
    rd_end();
  endtask
  // One serial clock period
  task automatic sclk_pulse();
    step(1);
    sclk_o = 1'b0;
    step(2);
    sclk_o = 1'b1;
    step(1);
  endtask
endmodule

// file: verification/adc_readout_mode_and_first_flag_properties.sv
`timescale 1ns/1ps
module adc_readout_checker (
  input wire logic                   mclk_i,                   // Clock
  input wire logic                   rst_i,                    // Reset
  input wire logic                   cs_n_i,                   // Select
  input wire logic                   rd_n_i,                   // Strobe
  input wire logic                   interface_select_i,       // Strap
  input wire logic                   top_bit_or_byte_sel_i,    // Strap
  input wire adc_readout_pkg::mode_t mode_o,                   // Mode
  input wire logic [15:0]            data_bus_o,               // Data
  input wire logic                   top_bit_oe_o,             // Top enable
  input wire logic                   data_bus_oe_o,            // Bus enable
  input wire logic                   first_channel_marker_o,   // Marker
  input wire logic                   first_channel_marker_oe_o // Marker enable
);
  import adc_readout_pkg::*;
  // Common clock and reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Strobe fall while selected
  sequence rd_fall;
    $fell(rd_n_i) && !cs_n_i;
  endsequence
  // Marker drive, mode and data checks
  a_oe_after_cs: assert property ($fell(cs_n_i) |-> ##[1:2] first_channel_marker_oe_o)
    else $error("marker not driven after select fall");
  a_oe_cause: assert property ($rose(first_channel_marker_oe_o)
    |-> $past(cs_n_i, 2) && !$past(cs_n_i)) else $error("marker driven without select");
  a_mode_word: assert property ((cs_n_i && !interface_select_i) [*3] |-> mode_o == MODE_WORD)
    else $error("word mode not taken");
  a_mode_byte: assert property ((cs_n_i && interface_select_i && top_bit_or_byte_sel_i) [*3]
    |-> mode_o == MODE_BYTE) else $error("byte mode not taken");
  a_top_oe_word: assert property (top_bit_oe_o
    |-> mode_o == MODE_WORD && !$past(rd_n_i) && !$past(cs_n_i))
    else $error("top pin driven outside word read");
  a_low_bits_zero: assert property (data_bus_oe_o && mode_o == MODE_WORD
    |-> data_bus_o[1:0] == 2'h0) else $error("low data bits not zero");
  a_word_drop: assert property (mode_o == MODE_WORD && first_channel_marker_o ##0 rd_fall
    |-> ##[1:2] !first_channel_marker_o) else $error("marker held past next read");
  a_byte_hold: assert property (mode_o == MODE_BYTE && $rose(first_channel_marker_o)
    |-> first_channel_marker_o [*8]) else $error("marker dropped before second byte");
endmodule
bind adc_readout_mode_and_first_flag adc_readout_checker adc_readout_checker_i (.*);

// file: verification/adc_readout_mode_and_first_flag_tb_top.sv
`timescale 1ns/1ps
module adc_readout_mode_and_first_flag_tb_top;
  logic         mclk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         conv_done_i = 1'b0;
  logic [111:0] results_i;
  logic         ce_i = 1'b1;
  logic         cs_n_i, rd_n_i, sclk_i, sa, sb, mk, mk_oe, top_oe, db_oe;
  adc_readout_pkg::mode_t mode;
  logic [2:0]   strap;
  logic [15:0]  db;
  int           error_cnt = 0;
  int           compares = 0;
  // Clock
  always #5 mclk_i = ~mclk_i;
  adc_host_model adc_host_model_i (.mclk_i(mclk_i), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
    .sclk_o(sclk_i), .strap_o(strap));
  adc_readout_mode_and_first_flag adc_readout_mode_and_first_flag_i (.mclk_i(mclk_i),
    .rst_i(rst_i), .ce_i(ce_i), .conv_done_i(conv_done_i), .results_i(results_i),
    .interface_select_i(strap[2]), .top_bit_or_byte_sel_i(strap[1]),
    .byte_order_select_i(strap[0]), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .sclk_i(sclk_i),
    .mode_o(mode), .data_bus_o(db), .top_bit_oe_o(top_oe), .data_bus_oe_o(db_oe),
    .serial_out_a_o(sa), .serial_out_b_o(sb), .first_channel_marker_o(mk),
    .first_channel_marker_oe_o(mk_oe));
  // Per-channel result pattern
  function automatic logic [15:0] res(input int c);
    return 16'(14'(c * 16'h0A5B + 16'h1C3D));
  endfunction
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // New conversion in the given mode, then select
  task automatic start(input logic [2:0] s);
    adc_host_model_i.set_strap(s);
    conv_done_i = 1'b1;
    adc_host_model_i.step(1);
    conv_done_i = 1'b0;
    adc_host_model_i.frame(1'b0);
  endtask
  // Word mode over all eight channels, one strobe while frozen
  task automatic t_word();
    check(16'(mk_oe), 16'h0000);
    start(3'h0);
    check(16'(mode), 16'(adc_readout_pkg::MODE_WORD));
    for (int c = 1; c <= 8; c++) begin
      if (c == 4) begin
        ce_i = 1'b0;
        adc_host_model_i.rd_pulse();
        ce_i = 1'b1;
        check(db, res(3) << 2);
      end
      adc_host_model_i.rd_begin();
      check({14'h0, top_oe, db_oe}, 16'h0003);
      adc_host_model_i.rd_end();
      check(db, res(c) << 2);
      check(16'(mk), 16'(c == 1));
    end
    check({14'h0, top_oe, db_oe}, 16'h0000);
    adc_host_model_i.frame(1'b1);
  endtask
  // Byte mode, both byte orders
  task automatic t_byte(input logic hi_first);
    logic [15:0] w;
    start({2'h3, hi_first});
    check(16'(mode), 16'(adc_readout_pkg::MODE_BYTE));
    for (int i = 0; i < 4; i++) begin
      w = res(i / 2 + 1);
      adc_host_model_i.rd_begin();
      check({14'h0, top_oe, db_oe}, 16'h0001);
      adc_host_model_i.rd_end();
      check(16'(db[7:0]), 16'((i % 2 == int'(hi_first)) ? w[7:0] : w[15:8]));
      check(16'(mk), 16'(i < 2));
    end
    adc_host_model_i.frame(1'b1);
  endtask
  // Reset in mid-run, then marker drive re-armed by select
  task automatic t_reset();
    adc_host_model_i.step(1);
    rst_i = 1'b1;
    adc_host_model_i.step(2);
    check({13'h0, mk_oe, mk, top_oe}, 16'h0000);
    check(16'(mode), 16'(adc_readout_pkg::MODE_WORD));
    rst_i = 1'b0;
    start(3'h0);
    check(16'(mk_oe), 16'h0001);
    adc_host_model_i.rd_pulse();
    check(db, res(1) << 2);
    check(16'(mk), 16'h0001);
  endtask
  // Serial mode, marker over fourteen clocks
  task automatic t_serial();
    start(3'h4);
    check(16'(mode), 16'(adc_readout_pkg::MODE_SERIAL));
    check({14'h0, top_oe, db_oe}, 16'h0000);
    check(16'(sa), res(1) >> 13);
    check(16'(sb), res(5) >> 13);
    check(16'(mk), 16'h0001);
    repeat (13) adc_host_model_i.sclk_pulse();
    check(16'(mk), 16'h0001);
    adc_host_model_i.sclk_pulse();
    check(16'(mk), 16'h0000);
    adc_host_model_i.frame(1'b1);
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    for (int c = 1; c <= 8; c++) results_i[(c-1)*14 +: 14] = 14'(res(c));
    repeat (5) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_word();
    t_byte(1'b0);
    t_byte(1'b1);
    t_serial();
    t_reset();
    final_report();
  end
  // Hang guard
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule
